// >>> common/serial_hs_map.svh
// Register offsets, field positions, reset values and limits of the serial helper.
`ifndef SERIAL_HS_MAP_SVH
`define SERIAL_HS_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define SH_ADDR_CTRL     12'h000
`define SH_ADDR_REQCNT   12'h004
`define SH_ADDR_MOVED    12'h008
`define SH_ADDR_MASKS    12'h00C
`define SH_ADDR_FLAGS    12'h010
`define SH_ADDR_ERRCODE  12'h014
`define SH_ADDR_IRQSTAT  12'h018
`define SH_ADDR_IRQCLR   12'h01C
`define SH_ADDR_IRQEN    12'h020
`define SH_ADDR_DEST     12'h100

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SH_CTRL_RUNG     0
`define SH_CTRL_OPSEL    1
`define SH_CTRL_CHAN_LO  8
`define SH_CTRL_CHAN_HI  15
`define SH_MASK_RTS      1
`define SH_SETMASK_LO    16
`define SH_FLAG_ARMED    0
`define SH_FLAG_WAIT     1
`define SH_FLAG_ACTIVE   2
`define SH_FLAG_DONE     3
`define SH_FLAG_FAULT    4
`define SH_EVT_FETCH     0
`define SH_EVT_LINE      1
`define SH_EVT_FAULT     2

// ----------------------------------------------------------------------------
// Values and limits
// ----------------------------------------------------------------------------
`define SH_PORT_A        8'h00
`define SH_PORT_B        8'h02
`define SH_MAX_CHARS     7'h52
`define SH_ERR_CHANNEL   16'h0001
`define SH_ERR_BUSY      16'h0002
`define SH_RESP_OKAY     2'h0
`define SH_RESP_SLVERR   2'h2
`define SH_RTS_RESET     1'h0

`endif

// >>> common/serial_hs_pkg.sv
// Types shared by the serial helper design files.
`default_nettype none
package serial_hs_pkg;
    // Character-fetch sequencing states.
    typedef enum logic [1:0] {FETCH_IDLE, FETCH_QUEUED, FETCH_RUN} fetch_state_t;
    typedef logic [15:0] word16_t;
    typedef logic [6:0]  char_count_t;
    typedef logic [7:0]  char_t;
endpackage
`default_nettype wire

// >>> hw/rts_line_ctrl.sv
// Request-to-send line driver for one serial channel.
`timescale 1ns/1ps
`default_nettype none
`include "serial_hs_map.svh"
module rts_line_ctrl (
    // Clock and reset.
    input  wire logic clk_sys,
    input  wire logic rst,
    // Line-control command.
    input  wire logic exec,
    input  wire logic clrBit,
    input  wire logic setBit,
    // Modem line.
    output logic      rts
);
    // ------------------------------------------------------------------------
    // Line register
    // ------------------------------------------------------------------------
    // Clear applies first and set second, so both together leave it asserted.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rts <= `SH_RTS_RESET;
        end else if (exec) begin
            rts <= (rts & ~clrBit) | setBit;
        end
    end
endmodule // rts_line_ctrl
`default_nettype wire

// >>> hw/irq_status.sv
// Sticky event status with write-one-to-clear, enable mask and one interrupt line.
`timescale 1ns/1ps
`default_nettype none
module irq_status #(
    parameter int N = 3
) (
    // Clock and reset.
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // Events and software access.
    input  wire logic [N-1:0] evt,
    input  wire logic         clrWe,
    input  wire logic [N-1:0] clrData,
    input  wire logic         enWe,
    input  wire logic [N-1:0] enData,
    // State and interrupt.
    output logic      [N-1:0] status,
    output logic      [N-1:0] enable,
    output logic              irq
);
    // ------------------------------------------------------------------------
    // Sticky bits
    // ------------------------------------------------------------------------
    // A set in the same cycle as a clear wins, so no event is lost.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            status <= '0;
        end else begin
            status <= (status & ~(clrWe ? clrData : '0)) | evt;
        end
    end

    // Enable register written by software.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            enable <= '0;
        end else if (enWe) begin
            enable <= enData;
        end
    end

    // Interrupt output is registered from the next masked status, so it changes in the same cycle as the status.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((status & ~(clrWe ? clrData : '0)) | evt) & (enWe ? enData : enable));
        end
    end
endmodule // irq_status
`default_nettype wire

// >>> hw/serial_handshake_top.sv
// Serial helper: handshake line control and character fetch behind AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "serial_hs_map.svh"

module serial_handshake_top #(
    parameter int NCH   = 2,
    parameter int AW    = 12,
    parameter int DEPTH = 82
) (
    // Clock and reset.
    input  wire logic                              clk_sys,
    input  wire logic                              rst,
    // AXI4-Lite write address and data.
    input  wire logic [AW-1:0]                     awaddr,
    input  wire logic                              awvalid,
    output logic                                   awready,
    input  wire logic [31:0]                       wdata,
    input  wire logic [3:0]                        wstrb,
    input  wire logic                              wvalid,
    output logic                                   wready,
    // AXI4-Lite write response.
    output logic [1:0]                             bresp,
    output logic                                   bvalid,
    input  wire logic                              bready,
    // AXI4-Lite read.
    input  wire logic [AW-1:0]                     araddr,
    input  wire logic                              arvalid,
    output logic                                   arready,
    output logic [31:0]                            rdata,
    output logic [1:0]                             rresp,
    output logic                                   rvalid,
    input  wire logic                              rready,
    // Modem handshake lines, slot 0 is port 0 and slot 1 is port 2.
    input  wire logic [NCH-1:0]                    ctsIn,
    output logic      [NCH-1:0]                    rtsOut,
    // Receive buffers, head character shown while level is nonzero.
    input  wire logic [NCH-1:0][7:0]               rxLevel,
    input  wire logic [NCH-1:0][7:0]               rxData,
    output logic      [NCH-1:0]                    rxPop,
    // Interrupt.
    output logic                                   irq
);
    import serial_hs_pkg::*;

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [AW-1:0]          awAddr_r;
    logic                   awHeld_r;
    logic [31:0]            wData_r;
    logic [3:0]             wStrb_r;
    logic                   wHeld_r;
    logic                   doWrite;
    logic [31:0]            wMask;
    logic [31:0]            rdMux;
    logic                   rdHit;
    logic                   wrHit;
    logic                   scan;
    logic                   rungNew;
    logic                   opLine;
    logic [7:0]             chanNew;
    logic                   chanOk;
    logic                   slotNew;
    logic                   rising;
    logic                   busy;
    logic                   lineGo;
    logic                   fetchGo;
    logic                   fault;
    logic                   rungPrev_r;
    logic                   slot_r;
    logic                   linePend_r;
    word16_t                reqCount_r;
    word16_t                clrMask_r;
    word16_t                setMask_r;
    word16_t                moved_r;
    word16_t                errCode_r;
    logic [4:0]             flags_r;
    fetch_state_t           state_r;
    char_count_t            target_r;
    char_count_t            targetNxt;
    char_t                  destStr_r [DEPTH];
    logic [AW-1:0]          destIdx;
    logic [2:0]             evt;
    logic [2:0]             irqStat;
    logic [2:0]             irqEn;
    logic [NCH-1:0]         lineExec;

    // ------------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------------
    // Address and data are taken in either order and held until both are in.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            awHeld_r <= 1'b0;
            awAddr_r <= '0;
            awready  <= 1'b0;
        end else begin
            awready <= !awHeld_r && !(awvalid && awready) && !doWrite && !bvalid;
            if (awvalid && awready) begin
                awHeld_r <= 1'b1;
                awAddr_r <= awaddr;
            end else if (doWrite) begin
                awHeld_r <= 1'b0;
            end
        end
    end

    // Write data holding register.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wHeld_r <= 1'b0;
            wData_r <= '0;
            wStrb_r <= '0;
            wready  <= 1'b0;
        end else begin
            wready <= !wHeld_r && !(wvalid && wready) && !doWrite && !bvalid;
            if (wvalid && wready) begin
                wHeld_r <= 1'b1;
                wData_r <= wdata;
                wStrb_r <= wstrb;
            end else if (doWrite) begin
                wHeld_r <= 1'b0;
            end
        end
    end

    // The write lands one cycle after both halves are held.
    assign doWrite = awHeld_r && wHeld_r && !bvalid;
    assign wMask   = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}}, {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};

    // Write response, error for addresses outside the writable set.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bvalid <= 1'b0;
            bresp  <= `SH_RESP_OKAY;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            bresp  <= wrHit ? `SH_RESP_OKAY : `SH_RESP_SLVERR;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    // Writable addresses.
    always_comb begin
        case (awAddr_r)
            `SH_ADDR_CTRL, `SH_ADDR_REQCNT, `SH_ADDR_MASKS,
            `SH_ADDR_IRQCLR, `SH_ADDR_IRQEN: wrHit = 1'b1;
            default:                          wrHit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------------
    // Request count and the two masks keep their value until rewritten.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reqCount_r <= '0;
            clrMask_r  <= '0;
            setMask_r  <= '0;
        end else if (doWrite) begin
            if (awAddr_r == `SH_ADDR_REQCNT) begin
                reqCount_r <= (reqCount_r & ~wMask[15:0]) | (wData_r[15:0] & wMask[15:0]);
            end
            if (awAddr_r == `SH_ADDR_MASKS) begin
                clrMask_r <= (clrMask_r & ~wMask[15:0]) | (wData_r[15:0] & wMask[15:0]);
                setMask_r <= (setMask_r & ~wMask[31:16]) | (wData_r[31:16] & wMask[31:16]);
            end
        end
    end

    // ------------------------------------------------------------------------
    // Scan decode
    // ------------------------------------------------------------------------
    // Each control write with byte lanes 0 and 1 strobed is one scan of the operation with the given rung state.
    assign scan    = doWrite && (awAddr_r == `SH_ADDR_CTRL) && wStrb_r[0] && wStrb_r[1];
    assign rungNew = wData_r[`SH_CTRL_RUNG];
    assign opLine  = !wData_r[`SH_CTRL_OPSEL];
    assign chanNew = wData_r[`SH_CTRL_CHAN_HI:`SH_CTRL_CHAN_LO];
    assign chanOk  = (chanNew == `SH_PORT_A) || (chanNew == `SH_PORT_B);
    assign slotNew = (chanNew == `SH_PORT_B);
    assign rising  = rungNew && !rungPrev_r;
    assign busy    = (state_r != FETCH_IDLE) || linePend_r;
    assign lineGo  = scan && chanOk && opLine && !busy;
    assign fetchGo = scan && chanOk && !opLine && rising && !busy;
    assign fault   = scan && (!chanOk || (busy && opLine));

    // Clip the request: zero or above the limit both mean the limit.
    always_comb begin
        if (reqCount_r == '0 || reqCount_r > {9'h000, `SH_MAX_CHARS}) begin
            targetNxt = `SH_MAX_CHARS;
        end else begin
            targetNxt = reqCount_r[6:0];
        end
    end

    // Rung history and selected channel slot.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rungPrev_r <= 1'b0;
            slot_r     <= 1'b0;
        end else if (scan) begin
            rungPrev_r <= rungNew;
            if ((lineGo || fetchGo)) begin
                slot_r <= slotNew;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Handshake line drivers
    // ------------------------------------------------------------------------
    // One driver per channel, only the selected one executes.
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_line
            assign lineExec[gi] = lineGo && (slotNew == 1'(gi));
            rts_line_ctrl u_rts (
                .clk_sys (clk_sys),
                .rst     (rst),
                .exec    (lineExec[gi]),
                .clrBit  (clrMask_r[`SH_MASK_RTS]),
                .setBit  (setMask_r[`SH_MASK_RTS]),
                .rts     (rtsOut[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Operation sequencing, flags and moved word
    // ------------------------------------------------------------------------
    // Line status is captured the cycle after the driver updates.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_r     <= FETCH_IDLE;
            flags_r     <= '0;
            moved_r     <= '0;
            target_r    <= '0;
            linePend_r  <= 1'b0;
            rxPop       <= '0;
        end else begin
            linePend_r <= lineGo;
            if (scan) begin
                // Armed only on a rung rise, dropped when the rung goes false.
                if (rising) begin
                    flags_r[`SH_FLAG_ARMED] <= 1'b1;
                end else if (!rungNew) begin
                    flags_r[`SH_FLAG_ARMED] <= 1'b0;
                end
            end
            if (lineGo || fetchGo) begin
                flags_r[`SH_FLAG_DONE] <= 1'b0;
            end
            if (linePend_r) begin
                moved_r <= {14'h0000, rtsOut[slot_r], ctsIn[slot_r]};
                flags_r[`SH_FLAG_DONE] <= 1'b1;
            end
            case (state_r)
                FETCH_IDLE: begin
                    if (fetchGo) begin
                        state_r                <= FETCH_QUEUED;
                        target_r               <= targetNxt;
                        moved_r                <= '0;
                        flags_r[`SH_FLAG_WAIT] <= 1'b1;
                    end
                end
                FETCH_QUEUED: begin
                    // Wait until the whole request sits in the buffer.
                    if (rxLevel[slot_r] >= {1'b0, target_r}) begin
                        state_r                  <= FETCH_RUN;
                        flags_r[`SH_FLAG_WAIT]   <= 1'b0;
                        flags_r[`SH_FLAG_ACTIVE] <= 1'b1;
                        rxPop[slot_r]            <= 1'b1;
                    end
                end
                FETCH_RUN: begin
                    // One character per cycle, count kept live.
                    moved_r <= moved_r + 16'h0001;
                    if (moved_r[6:0] + 7'h01 == target_r) begin
                        state_r                  <= FETCH_IDLE;
                        rxPop                    <= '0;
                        flags_r[`SH_FLAG_ACTIVE] <= 1'b0;
                        flags_r[`SH_FLAG_DONE]   <= 1'b1;
                    end
                end
                default: begin
                    state_r <= FETCH_IDLE;
                    rxPop   <= '0;
                end
            endcase
            if (fault) begin
                flags_r[`SH_FLAG_FAULT] <= 1'b1;
            end else if (lineGo || fetchGo) begin
                flags_r[`SH_FLAG_FAULT] <= 1'b0;
            end
        end
    end

    // Error code accompanies every fault.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            errCode_r <= '0;
        end else if (fault) begin
            errCode_r <= chanOk ? `SH_ERR_BUSY : `SH_ERR_CHANNEL;
        end else if (lineGo || fetchGo) begin
            errCode_r <= '0;
        end
    end

    // Destination string, written only while popping, index below the limit.
    always_ff @(posedge clk_sys) begin
        if (state_r == FETCH_RUN) begin
            destStr_r[moved_r[6:0]] <= rxData[slot_r];
        end
    end

    // ------------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------------
    assign evt[`SH_EVT_FETCH] = (state_r == FETCH_RUN) && (moved_r[6:0] + 7'h01 == target_r);
    assign evt[`SH_EVT_LINE]  = linePend_r;
    assign evt[`SH_EVT_FAULT] = fault;

    irq_status #(
        .N (3)
    ) u_irq (
        .clk_sys (clk_sys),
        .rst     (rst),
        .evt     (evt),
        .clrWe   (doWrite && (awAddr_r == `SH_ADDR_IRQCLR) && wStrb_r[0]),
        .clrData (wData_r[2:0]),
        .enWe    (doWrite && (awAddr_r == `SH_ADDR_IRQEN) && wStrb_r[0]),
        .enData  (wData_r[2:0]),
        .status  (irqStat),
        .enable  (irqEn),
        .irq     (irq)
    );

    // ------------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------------
    assign destIdx = (araddr - `SH_ADDR_DEST) >> 2;

    // Read decode, unmapped addresses read zero with an error response.
    always_comb begin
        rdHit = 1'b1;
        rdMux = '0;
        case (araddr)
            `SH_ADDR_CTRL:    rdMux = {16'h0000, 7'h00, slot_r, 6'h00, !linePend_r, rungPrev_r};
            `SH_ADDR_REQCNT:  rdMux = {16'h0000, reqCount_r};
            `SH_ADDR_MOVED:   rdMux = {16'h0000, moved_r};
            `SH_ADDR_MASKS:   rdMux = {setMask_r, clrMask_r};
            `SH_ADDR_FLAGS:   rdMux = {27'h0000000, flags_r};
            `SH_ADDR_ERRCODE: rdMux = {16'h0000, errCode_r};
            `SH_ADDR_IRQSTAT: rdMux = {29'h00000000, irqStat};
            `SH_ADDR_IRQEN:   rdMux = {29'h00000000, irqEn};
            default: begin
                if (araddr >= `SH_ADDR_DEST && destIdx < AW'(DEPTH) && araddr[1:0] == 2'h0) begin
                    rdMux = {24'h000000, destStr_r[destIdx[6:0]]};
                end else begin
                    rdHit = 1'b0;
                end
            end
        endcase
    end

    // One read at a time, answered the cycle after the address is taken.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= `SH_RESP_OKAY;
        end else begin
            arready <= !rvalid && !(arvalid && arready);
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rdata  <= rdMux;
                rresp  <= rdHit ? `SH_RESP_OKAY : `SH_RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end
endmodule // serial_handshake_top
`default_nettype wire

// >>> tb/serial_hs_props.sv
// Port checker of the serial helper, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module serial_hs_props (
    // Clock, reset and handshakes.
    input wire logic            clk_sys, rst, awvalid, awready, bvalid, bready,
    input wire logic            arvalid, arready, rvalid, rready,
    // Payloads and line signals.
    input wire logic [1:0]      bresp, rtsOut, rxPop,
    input wire logic [31:0]     rdata,
    input wire logic [1:0][7:0] rxLevel
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence wrHeld; bvalid && !bready; endsequence
    sequence rdHeld; rvalid && !rready; endsequence
    logic [7:0] popRun_r;
    // Length of the current run of pops, so an over-long fetch shows up.
    always_ff @(posedge clk_sys) popRun_r <= (rst || !(|rxPop)) ? 8'h00 : popRun_r + 8'h01;
    aw_taken_a: assert property (awvalid && awready |=> !awready)
        else $error("awready held after handshake");
    bresp_hold_a: assert property (wrHeld |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    read_answer_a: assert property (arvalid && arready |=> rvalid)
        else $error("read data late");
    rdata_hold_a: assert property (rdHeld |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    rts_on_write_a: assert property ($changed(rtsOut) |-> $rose(bvalid))
        else $error("rts moved without a write");
    pop_avail_a: assert property (rxPop[0] |-> rxLevel[0] != 8'h00)
        else $error("pop from empty buffer 0");
    pop_slot_a: assert property (rxPop[1] |-> rxLevel[1] != 8'h00)
        else $error("pop from empty buffer 1");
    pop_limit_a: assert property (|rxPop |-> popRun_r < 8'h52)
        else $error("more than 82 pops in a run");
endmodule // serial_hs_props
bind serial_handshake_top serial_hs_props i_props (.clk_sys, .rst, .awvalid, .awready,
    .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .bresp, .rtsOut, .rxPop,
    .rdata, .rxLevel);
`default_nettype wire

// >>> tb/rx_peer.sv
// Receive-buffer model of the serial peer feeding the character fetch.
`timescale 1ns/1ps
`default_nettype none
module rx_peer (
    // Clock.
    input  wire logic            clk_sys,
    // Buffer interface.
    input  wire logic [1:0]      rxPop,
    output logic      [1:0][7:0] rxLevel,
    output logic      [1:0][7:0] rxData
);
    logic [7:0] q[2][$];
    logic [7:0] last[2] = '{8'h00, 8'h00};
    // Shows level and head; an empty buffer shows the inverse of its last character.
    task automatic show();
        for (int s = 0; s < 2; s++) begin
            rxLevel[s] <= 8'(q[s].size());
            rxData[s] <= (q[s].size() > 0) ? q[s][0] : ~last[s];
        end
    endtask
    task automatic put(input int s, input logic [7:0] c);
        q[s].push_back(c);
        show();
    endtask
    task automatic flush();
        q[0].delete();
        q[1].delete();
        show();
    endtask
    // Consumes one head character at each edge where the fetch pops.
    always @(posedge clk_sys) begin
        for (int s = 0; s < 2; s++) if (rxPop[s] && q[s].size() > 0) last[s] = q[s].pop_front();
        show();
    end
    initial show();
endmodule // rx_peer
`default_nettype wire

// >>> tb/serial_handshake_top_tb.sv
// Self-checking bench of the serial helper.
`timescale 1ns/1ps
`default_nettype none
`include "serial_hs_map.svh"
`define CHK(a, e) begin checksDone++; if ((a) !== (e)) begin badCount++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module serial_handshake_top_tb;
    logic clk_sys = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d, seed = 32'h17CB;
    logic [1:0] bresp, rresp, r, ctsIn = 0, rtsOut, rxPop, rts = 0;
    logic [1:0][7:0] rxLevel, rxData;
    int badCount = 0, checksDone = 0, n;
    int pat[5] = '{2, 0, 1, 0, 3};
    int lens[3] = '{3, 0, 90};
    logic [7:0] expQ[$];
    serial_handshake_top i_serial_handshake_top (.clk_sys, .rst, .awaddr, .awvalid, .awready,
        .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .ctsIn, .rtsOut, .rxLevel, .rxData,
        .rxPop, .irq);
    rx_peer i_rx_peer (.clk_sys, .rxPop, .rxLevel, .rxData);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic conclude();
        if (badCount == 0 && checksDone > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Register write; each channel is released at the edge that takes it.
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1;
        do begin
            @(posedge clk_sys);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        // Ready comes a cycle late, so the held response is exercised.
        bready <= 1;
        @(posedge clk_sys);
        r = bresp;
        bready <= 0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge clk_sys);
        araddr <= a; arvalid <= 1;
        do begin
            @(posedge clk_sys);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        // Ready comes a cycle late, so the held read data is exercised.
        rready <= 1;
        @(posedge clk_sys);
        d = rdata;
        rready <= 0;
        `CHK(rresp, `SH_RESP_OKAY)
    endtask
    // Queues one random character at the peer and in the expected string.
    task automatic push();
        seed = lfsr(seed);
        expQ.push_back(seed[7:0]);
        i_rx_peer.put(0, seed[7:0]);
    endtask
    initial forever #10 clk_sys = ~clk_sys;
    initial begin
        #1000000;
        badCount++;
        conclude();
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 0;
        wr(`SH_ADDR_IRQEN, 32'h7);
        // Line control on both ports: keep, clear, set and both masks.
        for (int c = 0; c < 2; c++) foreach (pat[i]) begin
            seed = lfsr(seed);
            ctsIn <= seed[1:0];
            rts[c] = pat[i][1] ? 1'b1 : pat[i][0] ? 1'b0 : rts[c];
            wr(`SH_ADDR_MASKS, {14'h0, pat[i][1], 15'h0, pat[i][0], 1'b0});
            wr(`SH_ADDR_CTRL, {16'h0, 8'(2 * c), 7'h0, seed[2]});
            `CHK(rtsOut[c], rts[c])
            rd(`SH_ADDR_MOVED);
            `CHK(d, {30'h0, rts[c], ctsIn[c]})
        end
        wr(`SH_ADDR_CTRL, 32'h100);
        rd(`SH_ADDR_ERRCODE);
        `CHK(d, 32'h1)
        rd(`SH_ADDR_FLAGS);
        `CHK(d[4], 1'b1)
        wr(`SH_ADDR_MOVED, 32'h0);
        `CHK(r, `SH_RESP_SLVERR)
        // Character fetch at a small count, zero and above the limit.
        foreach (lens[k]) begin
            n = (lens[k] == 0 || lens[k] > 82) ? 82 : lens[k];
            repeat (n - 1) push();
            wr(`SH_ADDR_REQCNT, 32'(lens[k]));
            rd(`SH_ADDR_REQCNT);
            `CHK(d[15:0], 16'(lens[k]))
            wr(`SH_ADDR_CTRL, 32'h2);
            wr(`SH_ADDR_CTRL, 32'h3);
            rd(`SH_ADDR_FLAGS);
            `CHK(d[2:1], 2'b01)
            repeat (2) push();
            for (int t = 0; t < 300 && !d[3]; t++) rd(`SH_ADDR_FLAGS);
            `CHK(d[3], 1'b1)
            rd(`SH_ADDR_MOVED);
            `CHK(d, 32'(n))
            `CHK(rxLevel[0], 8'h01)
            for (int i = 0; i < n; i++) begin
                rd(`SH_ADDR_DEST + 12'(4 * i));
                `CHK(d[7:0], expQ[i])
            end
            wr(`SH_ADDR_CTRL, 32'h3);
            rd(`SH_ADDR_FLAGS);
            `CHK(d[1], 1'b0)
            i_rx_peer.flush();
            expQ.delete();
        end
        // Interrupt: raised, cleared, masked and enabled again.
        `CHK(irq, 1'b1)
        wr(`SH_ADDR_IRQCLR, 32'h7);
        wr(`SH_ADDR_IRQEN, 32'h0);
        wr(`SH_ADDR_CTRL, 32'h0);
        rd(`SH_ADDR_IRQSTAT);
        `CHK(d[1:0], 2'b10)
        `CHK(irq, 1'b0)
        wr(`SH_ADDR_IRQEN, 32'h2);
        rd(`SH_ADDR_IRQSTAT);
        `CHK(irq, 1'b1)
        conclude();
    end
endmodule // serial_handshake_top_tb
`default_nettype wire
